// ### rtl/hpp_map.svh
`ifndef HPP_MAP_SVH
`define HPP_MAP_SVH
// Flag update deadline after transaction end, in ns
`define HPP_FLAG_UPD_NS     15
`define HPP_CLK_PERIOD_NS   5
// Longest time rounds down, at least one cycle
`define HPP_FLAG_UPD_CYC    ((`HPP_FLAG_UPD_NS / `HPP_CLK_PERIOD_NS) < 1 ? 1 : (`HPP_FLAG_UPD_NS / `HPP_CLK_PERIOD_NS))
`define HPP_BYTE_W          8
`define HPP_WORD_W          16
`define HPP_BUF_DEPTH       2
`define HPP_LO_BYTE_MSB     7
`define HPP_HI_BYTE_LSB     8
`endif

// ### rtl/hpp_pkg.sv
package hpp_pkg;
  typedef enum logic [1:0] {
    HPP_IDLE  = 2'b00,
    HPP_READ  = 2'b01,
    HPP_WRITE = 2'b10
  } hpp_state_e;
  typedef logic [15:0] hpp_word_t;
  typedef logic [7:0]  hpp_byte_t;
endpackage

// ### rtl/hpp_buf2.sv
`timescale 1ns/1ps
`include "hpp_map.svh"
module hpp_buf2
  import hpp_pkg::*;
(
  input  wire logic      clk_sys_in,
  input  wire logic      sys_rst_in,
  input  wire logic      ce_in,
  input  wire logic      in_valid_in,
  output logic           in_ready_out,
  input  wire hpp_word_t in_data_in,
  output logic           out_valid_out,
  input  wire logic      out_ready_in,
  output hpp_word_t      out_data_out
);
  // ---------------------------------------------------------------
  // Two-entry circular buffer
  // ---------------------------------------------------------------
  hpp_word_t  mem_r [`HPP_BUF_DEPTH];
  logic       wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic       push, pop;

  assign in_ready_out  = (cnt_r != 2'h2);
  assign out_valid_out = (cnt_r != 2'h0);
  assign out_data_out  = mem_r[rp_r];
  assign push = ce_in && in_valid_in && in_ready_out;
  assign pop  = ce_in && out_valid_out && out_ready_in;

  always_comb begin
    wp_nxt  = wp_r ^ push;
    rp_nxt  = rp_r ^ pop;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
endmodule

// ### rtl/hpp_port.sv
`timescale 1ns/1ps
`include "hpp_map.svh"
// Summary of operation
// - Read starts when select and output strobe low
// - Read ends at first of either rising
// - Write starts when select and input strobe low
// - Write ends and captures at first rise
// - Controlling edge is reference for all timing
// - Single strobe: start at later active edge
// - Single strobe: end at earlier deassertion
// - Single strobe polarity is programmable
// - Empty/full flag polarity is programmable
// - Empty flag updates after read completes
// - Full flag updates after write completes
// - Byte access is half a word access
// - Reset shows output empty, input empty
module hpp_port
  import hpp_pkg::*;
(
  input  wire logic      clk_sys_in,
  input  wire logic      sys_rst_in,
  input  wire logic      ce_in,
  // Host side pins
  input  wire logic      port_chip_select_n_in,
  input  wire logic      output_data_strobe_n_in,
  input  wire logic      input_data_strobe_n_in,
  input  wire logic      single_data_strobe_in,
  input  wire logic      read_write_direction_in,
  input  wire logic      status_access_select_in,
  input  wire logic      byte_half_select_in,
  input  wire hpp_byte_t host_data_bus_in,
  output hpp_byte_t      host_data_bus_out,
  output logic           host_data_bus_oe_out,
  output logic           output_buffer_empty_flag_out,
  output logic           input_buffer_full_flag_out,
  // Configuration
  input  wire logic      single_strobe_mode_in,
  input  wire logic      strobe_active_high_in,
  input  wire logic      flags_inverted_in,
  input  wire hpp_byte_t status_byte_in,
  // Device side: words to the host
  input  wire logic      tx_valid_in,
  output logic           tx_ready_out,
  input  wire hpp_word_t tx_data_in,
  // Device side: words from the host
  output logic           rx_valid_out,
  input  wire logic      rx_ready_in,
  output hpp_word_t      rx_data_out
);
  // ---------------------------------------------------------------
  // Strobe synchronisers
  // ---------------------------------------------------------------
  logic [2:0] s1_r, s2_r;
  logic [2:0] raw_act;

  always_comb begin
    raw_act[0] = ~port_chip_select_n_in;
    raw_act[1] = single_strobe_mode_in ? (single_data_strobe_in == strobe_active_high_in)
                                       : ~output_data_strobe_n_in;
    raw_act[2] = single_strobe_mode_in ? 1'b0 : ~input_data_strobe_n_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
    end else if (ce_in) begin
      s1_r <= raw_act;
      s2_r <= s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Transaction framing
  // ---------------------------------------------------------------
  hpp_state_e st_r, st_nxt;
  logic       rd_frame, wr_frame;
  logic       rd_end, wr_end;
  logic       dir_read_r, dir_read_nxt;
  logic       stat_r, stat_nxt;
  logic       hi_r, hi_nxt;

  // Both qualifiers active; the later edge starts, the earlier deassertion ends
  assign rd_frame = s2_r[0] && s2_r[1] && (!single_strobe_mode_in || read_write_direction_in);
  assign wr_frame = s2_r[0] && (single_strobe_mode_in ? (s2_r[1] && !read_write_direction_in)
                                                      : s2_r[2]);
  assign rd_end = (st_r == HPP_READ)  && !(s2_r[0] && s2_r[1]);
  assign wr_end = (st_r == HPP_WRITE) && !(s2_r[0] && (single_strobe_mode_in ? s2_r[1] : s2_r[2]));

  always_comb begin
    st_nxt       = st_r;
    dir_read_nxt = dir_read_r;
    stat_nxt     = stat_r;
    hi_nxt       = hi_r;
    case (st_r)
      HPP_IDLE: begin
        // Direction line is not latched; in single strobe mode it selects read or write framing
        if (rd_frame) begin
          st_nxt   = HPP_READ;
          stat_nxt = status_access_select_in;
          hi_nxt   = byte_half_select_in;
        end else if (wr_frame) begin
          st_nxt   = HPP_WRITE;
          stat_nxt = status_access_select_in;
          hi_nxt   = byte_half_select_in;
        end
      end
      HPP_READ: begin
        if (rd_end) begin
          st_nxt = HPP_IDLE;
        end
      end
      HPP_WRITE: begin
        if (wr_end) begin
          st_nxt = HPP_IDLE;
        end
      end
      default: begin
        st_nxt = HPP_IDLE;
      end
    endcase
    dir_read_nxt = (st_nxt == HPP_READ);
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_r       <= HPP_IDLE;
      dir_read_r <= 1'b0;
      stat_r     <= 1'b0;
      hi_r       <= 1'b0;
    end else if (ce_in) begin
      st_r       <= st_nxt;
      dir_read_r <= dir_read_nxt;
      stat_r     <= stat_nxt;
      hi_r       <= hi_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Data path: output word, input word assembly
  // ---------------------------------------------------------------
  hpp_word_t obuf_r, obuf_nxt;
  logic      obuf_full_r, obuf_full_nxt;
  hpp_word_t iasm_r, iasm_nxt;
  logic      ibuf_full_r, ibuf_full_nxt;
  logic      rx_push;
  logic      rx_in_ready;
  hpp_byte_t dout_r, dout_nxt;
  logic      oe_r, oe_nxt;
  logic      rd_word_done, wr_word_done;

  // A word completes on the high half; byte access is one half of it
  assign rd_word_done = rd_end && !stat_r && hi_r;
  assign wr_word_done = wr_end && !stat_r && hi_r;
  assign tx_ready_out = !obuf_full_r || rd_word_done;

  always_comb begin
    obuf_nxt      = obuf_r;
    obuf_full_nxt = obuf_full_r;
    iasm_nxt      = iasm_r;
    ibuf_full_nxt = ibuf_full_r;
    rx_push       = 1'b0;
    if (rd_word_done) begin
      obuf_full_nxt = 1'b0;
    end
    if (tx_valid_in && tx_ready_out) begin
      obuf_nxt      = tx_data_in;
      obuf_full_nxt = 1'b1;
    end
    // Host data is stable at the ending edge and captured when the synchronised end is seen
    if (wr_end && !stat_r) begin
      if (hi_r) begin
        iasm_nxt[`HPP_WORD_W-1:`HPP_HI_BYTE_LSB] = host_data_bus_in;
        ibuf_full_nxt = 1'b1;
      end else begin
        iasm_nxt[`HPP_LO_BYTE_MSB:0] = host_data_bus_in;
      end
    end
    if (ibuf_full_r && rx_in_ready) begin
      rx_push       = 1'b1;
      ibuf_full_nxt = wr_word_done;
    end
    dout_nxt = stat_r ? status_byte_in
                      : (hi_r ? obuf_r[`HPP_WORD_W-1:`HPP_HI_BYTE_LSB] : obuf_r[`HPP_LO_BYTE_MSB:0]);
    oe_nxt   = dir_read_r && !rd_end;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      obuf_r      <= 16'h0000;
      obuf_full_r <= 1'b0;
      iasm_r      <= 16'h0000;
      ibuf_full_r <= 1'b0;
      dout_r      <= 8'h00;
      oe_r        <= 1'b0;
    end else if (ce_in) begin
      obuf_r      <= obuf_nxt;
      obuf_full_r <= obuf_full_nxt;
      iasm_r      <= iasm_nxt;
      ibuf_full_r <= ibuf_full_nxt;
      dout_r      <= dout_nxt;
      oe_r        <= oe_nxt;
    end
  end

  assign host_data_bus_out    = dout_r;
  assign host_data_bus_oe_out = oe_r;

  // Receiver stall does not lose a host word
  hpp_buf2 u_rx_buf (
    .clk_sys_in    (clk_sys_in),
    .sys_rst_in    (sys_rst_in),
    .ce_in         (ce_in),
    .in_valid_in   (rx_push),
    .in_ready_out  (rx_in_ready),
    .in_data_in    (iasm_r),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in),
    .out_data_out  (rx_data_out)
  );

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  logic oempty_r, oempty_nxt, ifull_r, ifull_nxt;

  always_comb begin
    oempty_nxt = !obuf_full_nxt;
    ifull_nxt  = ibuf_full_nxt;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      oempty_r <= 1'b1;
      ifull_r  <= 1'b0;
    end else if (ce_in) begin
      oempty_r <= oempty_nxt;
      ifull_r  <= ifull_nxt;
    end
  end

  assign output_buffer_empty_flag_out = oempty_r ^ flags_inverted_in;
  assign input_buffer_full_flag_out   = ifull_r ^ flags_inverted_in;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_rd_flag;
    @(posedge clk_sys_in) disable iff (sys_rst_in || !ce_in)
      rd_word_done && !(tx_valid_in) |=> oempty_r;
  endproperty
  a_rd_flag: assert property (p_rd_flag) else $error("empty flag not set after read");

  property p_wr_flag;
    @(posedge clk_sys_in) disable iff (sys_rst_in || !ce_in)
      wr_word_done |=> ifull_r;
  endproperty
  a_wr_flag: assert property (p_wr_flag) else $error("full flag not set after write");

  property p_rd_start;
    @(posedge clk_sys_in) disable iff (sys_rst_in || !ce_in)
      (st_r == HPP_IDLE) && !(s2_r[0] && s2_r[1]) |=> st_r != HPP_READ;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read started without both qualifiers");

  property p_rd_end;
    @(posedge clk_sys_in) disable iff (sys_rst_in || !ce_in)
      (st_r == HPP_READ) && !s2_r[0] |=> st_r == HPP_IDLE;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("read did not end on select rise");

  property p_wr_start;
    @(posedge clk_sys_in) disable iff (sys_rst_in || !ce_in)
      (st_r == HPP_IDLE) && !s2_r[0] |=> st_r == HPP_IDLE;
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("transaction started without select");

  property p_wr_end;
    @(posedge clk_sys_in) disable iff (sys_rst_in || !ce_in)
      (st_r == HPP_WRITE) && !s2_r[0] |=> st_r == HPP_IDLE;
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("write did not end on select rise");

  property p_oe_rd;
    @(posedge clk_sys_in) disable iff (sys_rst_in || !ce_in)
      oe_r |-> $past(st_r) == HPP_READ || st_r == HPP_READ;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("bus driven outside read");

  property p_flag_pol;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      $past(sys_rst_in) |-> output_buffer_empty_flag_out == !flags_inverted_in
                            && input_buffer_full_flag_out == flags_inverted_in;
  endproperty
  a_flag_pol: assert property (p_flag_pol) else $error("flag levels wrong after reset");
endmodule

// ### verif/hpp_host_model.sv
`timescale 1ns/1ps
module hpp_host_model
  import hpp_pkg::*;
(
  input  wire logic      clk_sys_in,
  input  wire logic      single_in,
  input  wire logic      act_high_in,
  input  wire hpp_byte_t bus_in,
  output logic           cs_n_out,
  output logic           ods_n_out,
  output logic           ids_n_out,
  output logic           sds_out,
  output logic           rwd_out,
  output logic           stat_out,
  output logic           bsel_out,
  output hpp_byte_t      data_out
);
  logic sds_act = 1'b0;
  initial begin
    cs_n_out = 1'b1;
    ods_n_out = 1'b1;
    ids_n_out = 1'b1;
    rwd_out = 1'b1;
    stat_out = 1'b0;
    bsel_out = 1'b0;
    data_out = 8'h00;
  end
  assign sds_out = act_high_in ? sds_act : ~sds_act;
  task automatic strobe(input logic rd, input logic on);
    if (single_in)
      sds_act <= on;
    else if (rd)
      ods_n_out <= ~on;
    else
      ids_n_out <= ~on;
  endtask
  // Selects and direction settle before the start and hold past the end
  task automatic xfer(input logic rd, input logic bs, input logic st, input logic cl,
                      input hpp_byte_t wd, output hpp_byte_t got);
    @(posedge clk_sys_in);
    rwd_out <= rd;
    stat_out <= st;
    bsel_out <= bs;
    data_out <= rd ? ~data_out : wd;
    @(posedge clk_sys_in);
    if (cl) strobe(rd, 1'b1);
    else cs_n_out <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    if (cl) cs_n_out <= 1'b0;
    else strobe(rd, 1'b1);
    repeat (8) @(posedge clk_sys_in);
    got = bus_in;
    if (cl) cs_n_out <= 1'b1;
    else strobe(rd, 1'b0);
    repeat (3) @(posedge clk_sys_in);
    if (cl) strobe(rd, 1'b0);
    else cs_n_out <= 1'b1;
    @(posedge clk_sys_in);
    data_out <= ~data_out;
  endtask
endmodule

// ### verif/tb_hpp_port.sv
`timescale 1ns/1ps
module tb_hpp_port
  import hpp_pkg::*;
;
  logic      clk_sys_in, sys_rst_in, ce, sgl, act_hi, inv, tx_valid, rx_ready;
  logic      cs_n, ods_n, ids_n, sds, rwd, stat, bsel, oe, empty_f, full_f, tx_ready, rx_valid;
  hpp_byte_t stat_b, bus_host, bus_dut, bus, got;
  hpp_word_t tx_data, rx_data;
  int        fails = 0;
  int        checked = 0;
  assign bus = oe ? bus_dut : bus_host;
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  hpp_port u_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
    .port_chip_select_n_in(cs_n), .output_data_strobe_n_in(ods_n), .input_data_strobe_n_in(ids_n),
    .single_data_strobe_in(sds), .read_write_direction_in(rwd), .status_access_select_in(stat),
    .byte_half_select_in(bsel), .host_data_bus_in(bus), .host_data_bus_out(bus_dut),
    .host_data_bus_oe_out(oe), .output_buffer_empty_flag_out(empty_f), .input_buffer_full_flag_out(full_f),
    .single_strobe_mode_in(sgl), .strobe_active_high_in(act_hi), .flags_inverted_in(inv),
    .status_byte_in(stat_b), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_data_in(tx_data),
    .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .rx_data_out(rx_data));
  hpp_host_model u_host (.clk_sys_in(clk_sys_in), .single_in(sgl), .act_high_in(act_hi), .bus_in(bus),
    .cs_n_out(cs_n), .ods_n_out(ods_n), .ids_n_out(ids_n), .sds_out(sds), .rwd_out(rwd),
    .stat_out(stat), .bsel_out(bsel), .data_out(bus_host));
  // ----------------------------------------
  // Checks and bus tasks
  // ----------------------------------------
  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_word(input string n, input hpp_word_t e, input hpp_word_t g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_sys_in);
  endtask
  task automatic push_tx(input hpp_word_t w);
    int n = 0;
    @(posedge clk_sys_in);
    tx_data <= w;
    tx_valid <= 1'b1;
    @(posedge clk_sys_in);
    while (tx_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_sys_in);
    end
    chk_bit("tx_ready", 1'b1, tx_ready);
    tx_valid <= 1'b0;
  endtask
  task automatic pop_rx(input hpp_word_t w);
    int n = 0;
    while (rx_valid !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_sys_in);
    end
    chk_bit("rx_valid", 1'b1, rx_valid);
    rx_ready <= 1'b1;
    @(posedge clk_sys_in);
    chk_word("rx_data", w, rx_data);
    rx_ready <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic wr_word(input hpp_word_t w, input logic cl);
    u_host.xfer(1'b0, 1'b0, 1'b0, cl, w[7:0], got);
    u_host.xfer(1'b0, 1'b1, 1'b0, ~cl, w[15:8], got);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk_bit("oe", 1'b0, oe);
    chk_bit("empty", 1'b1, empty_f);
    chk_bit("full", 1'b0, full_f);
    chk_bit("rx_valid", 1'b0, rx_valid);
    chk_bit("tx_ready", 1'b1, tx_ready);
    $display("test reset done");
  endtask
  task automatic t_freeze();
    ce <= 1'b0;
    wr_word(16'h5555, 1'b1);
    ce <= 1'b1;
    settle();
    chk_bit("rx_valid", 1'b0, rx_valid);
    chk_bit("full", inv, full_f);
    $display("test freeze done");
  endtask
  task automatic t_write();
    wr_word(16'h1234, 1'b1);
    wr_word(16'hbeef, 1'b0);
    wr_word(16'h0f5a, 1'b1);
    settle();
    chk_bit("full", ~inv, full_f);
    pop_rx(16'h1234);
    pop_rx(16'hbeef);
    pop_rx(16'h0f5a);
    settle();
    chk_bit("full", inv, full_f);
    u_host.xfer(1'b0, 1'b0, 1'b1, 1'b1, 8'h77, got);
    u_host.xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'h66, got);
    settle();
    chk_bit("rx_valid", 1'b0, rx_valid);
    $display("test write done");
  endtask
  task automatic t_read(input logic cl);
    push_tx(16'hc33c);
    settle();
    chk_bit("empty", inv, empty_f);
    u_host.xfer(1'b1, 1'b0, 1'b0, cl, 8'h00, got);
    chk_word("read lo", 16'h003c, {8'h00, got});
    settle();
    chk_bit("empty", inv, empty_f);
    u_host.xfer(1'b1, 1'b1, 1'b0, ~cl, 8'h00, got);
    chk_word("read hi", 16'h00c3, {8'h00, got});
    settle();
    chk_bit("empty", ~inv, empty_f);
    chk_bit("oe", 1'b0, oe);
    u_host.xfer(1'b1, 1'b0, 1'b1, cl, 8'h00, got);
    chk_word("status", {8'h00, stat_b}, {8'h00, got});
    $display("test read done");
  endtask
  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fails++;
    $display("BAD watchdog expected done seen timeout");
    report_and_stop();
  end
  initial begin
    sys_rst_in = 1'b1;
    ce = 1'b1;
    sgl = 1'b0;
    act_hi = 1'b0;
    inv = 1'b0;
    stat_b = 8'h5a;
    tx_valid = 1'b0;
    tx_data = 16'h0000;
    rx_ready = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_freeze();
    t_write();
    t_read(1'b1);
    for (int p = 0; p < 2; p++) begin
      sgl <= 1'b1;
      act_hi <= p[0];
      inv <= ~p[0];
      repeat (2) @(posedge clk_sys_in);
      chk_bit("empty", ~inv, empty_f);
      t_write();
      t_read(p[0]);
    end
    report_and_stop();
  end
endmodule
